// ===== include/ros_pkg.sv
// Constants and types shared by the radio operating-state controller.
package ros_pkg;

    // Clock rate and the settling time allowed for the local oscillator lock.
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_TIME_NS  = 500;
    localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CNT_W    = 16;

    // Widths of the command code and the general-purpose pin group.
    localparam int CMD_W  = 3;
    localparam int GPIO_W = 4;

    // Command codes carried by a decoded host command.
    localparam logic [CMD_W-1:0] CMD_NOP     = 3'h0;
    localparam logic [CMD_W-1:0] CMD_READY   = 3'h1;
    localparam logic [CMD_W-1:0] CMD_LOCK    = 3'h2;
    localparam logic [CMD_W-1:0] CMD_TX      = 3'h3;
    localparam logic [CMD_W-1:0] CMD_RX      = 3'h4;
    localparam logic [CMD_W-1:0] CMD_SLEEP   = 3'h5;
    localparam logic [CMD_W-1:0] CMD_STANDBY = 3'h6;

    // Operating states.
    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_READY,
        ST_LOCK,
        ST_TX,
        ST_RX,
        ST_SLEEP,
        ST_STANDBY
    } ros_state_e;

    // Radio activity still to be entered once the lock step is over.
    typedef enum logic [1:0] {
        GOAL_NONE,
        GOAL_TX,
        GOAL_RX
    } ros_goal_e;

endpackage

// ===== verification/ros_host_model.sv
// Host-side model that issues state commands and drives the shutdown pin.
`timescale 1ns/1ps
`default_nettype none
module ros_host_model
    import ros_pkg::*;
(
    input  wire logic             mclk_in,
    output logic                  shutdown_control_pin_out,
    output logic                  cmd_valid_out,
    output logic [CMD_W-1:0]      cmd_code_out
);
    initial begin
        shutdown_control_pin_out = 1'b0;
        cmd_valid_out = 1'b0;
        cmd_code_out = CMD_NOP;
    end
    // One strobe per command; the walk through LOCK is left to the device.
    task automatic send(input logic [CMD_W-1:0] c, input int gap);
        repeat (gap) @(negedge mclk_in);
        @(negedge mclk_in);
        cmd_valid_out = 1'b1;
        cmd_code_out = c;
        @(negedge mclk_in);
        cmd_valid_out = 1'b0;
        // The code lines are not held after the strobe, so they carry junk.
        cmd_code_out = ~c;
    endtask
    task automatic power(input logic off);
        @(negedge mclk_in);
        shutdown_control_pin_out = off;
    endtask
endmodule // ros_host_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the radio operating-state controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_top
    import ros_pkg::*;
;
    localparam int LOCKN = 8;
    logic mclk_in, rst_in, cfg_write_in, data_write_in, spi_miso_drive_in, pin, cvalid;
    logic [GPIO_W-1:0] gpio_drive_in, gpio_en_in, gpio_out, gpio_oe_out;
    logic [2:0] state_out, prev;
    logic [CMD_W-1:0] ccode;
    logic cmd_taken_out, cmd_ignored_out, crystal_reference_oscillator_on_out;
    logic local_oscillator_signal_on_out, lock_settled_out, tx_on_out, rx_on_out;
    logic spi_miso_out, spi_miso_oe_out, config_valid_out, data_valid_out;
    int fails = 0, tests_run = 0, cycles = 0;

    ros_host_model ros_host_model_inst (.mclk_in, .shutdown_control_pin_out(pin),
        .cmd_valid_out(cvalid), .cmd_code_out(ccode));
    ros_state_ctrl #(.LOCK_CYCLES_P(LOCKN)) ros_state_ctrl_inst (.mclk_in, .rst_in,
        .shutdown_control_pin_in(pin), .cmd_valid_in(cvalid), .cmd_code_in(ccode),
        .cfg_write_in, .data_write_in, .gpio_drive_in, .gpio_en_in, .spi_miso_drive_in,
        .state_out, .cmd_taken_out, .cmd_ignored_out, .crystal_reference_oscillator_on_out,
        .local_oscillator_signal_on_out, .lock_settled_out, .tx_on_out, .rx_on_out, .gpio_out,
        .gpio_oe_out, .spi_miso_out, .spi_miso_oe_out, .config_valid_out, .data_valid_out);

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    function automatic logic legal(logic [2:0] s, logic [2:0] c);
        case (c)
            CMD_READY: return s inside {ST_LOCK, ST_TX, ST_RX, ST_SLEEP, ST_STANDBY};
            CMD_LOCK: return s inside {ST_READY, ST_LOCK, ST_TX, ST_RX};
            CMD_TX: return s inside {ST_READY, ST_LOCK, ST_RX};
            CMD_RX: return s inside {ST_READY, ST_LOCK, ST_TX};
            CMD_SLEEP, CMD_STANDBY: return s == ST_READY;
            default: return 1'b0;
        endcase
    endfunction

    // The state a command finally leads to; refused commands leave it alone.
    function automatic logic [2:0] goal(logic [2:0] s, logic [2:0] c);
        if (!legal(s, c)) return s;
        case (c)
            CMD_READY: return ST_READY;
            CMD_LOCK: return ST_LOCK;
            CMD_TX: return ST_TX;
            CMD_RX: return ST_RX;
            CMD_SLEEP: return ST_SLEEP;
            default: return ST_STANDBY;
        endcase
    endfunction

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_outs(input logic [2:0] s);
        logic ref_on;
        ref_on = s inside {ST_READY, ST_LOCK, ST_TX, ST_RX};
        `CHK("tx_on", s == ST_TX, tx_on_out)
        `CHK("rx_on", s == ST_RX, rx_on_out)
        `CHK("ref_on", ref_on, crystal_reference_oscillator_on_out)
        `CHK("synth_on", ref_on && s != ST_READY, local_oscillator_signal_on_out)
        if (s != ST_LOCK) `CHK("settled", s inside {ST_TX, ST_RX}, lock_settled_out)
    endtask

    // Without settling, a further command may land while the lock is running.
    task automatic do_cmd(input logic [CMD_W-1:0] c, input int gap, input bit settle);
        logic [2:0] s0, g;
        logic ok;
        int n;
        s0 = state_out;
        ok = legal(s0, c);
        g = goal(s0, c);
        ros_host_model_inst.send(c, gap);
        `CHK("taken", ok, cmd_taken_out)
        `CHK("ignored", !ok, cmd_ignored_out)
        `CHK("state", (ok && c inside {CMD_TX, CMD_RX}) ? ST_LOCK : g, state_out)
        for (n = 0; settle && n < LOCKN + 8 && state_out === ST_LOCK && g !== ST_LOCK; n++)
            @(negedge mclk_in);
        if (settle && ok && s0 != ST_LOCK && g inside {ST_TX, ST_RX})
            `CHK("lock_time", LOCKN + 1, n)
        if (settle) begin
            `CHK("final", g, state_out)
            chk_outs(g);
        end
    endtask

    task automatic writes;
        cfg_write_in = 1'b1;
        data_write_in = 1'b1;
        @(negedge mclk_in);
        cfg_write_in = 1'b0;
        data_write_in = 1'b0;
    endtask

    task automatic shut;
        writes;
        ros_host_model_inst.power(1'b1);
        @(negedge mclk_in);
        `CHK("shut_state", ST_SHUTDOWN, state_out)
        `CHK("cfg_lost", 1'b0, config_valid_out)
        `CHK("data_lost", 1'b0, data_valid_out)
        ros_host_model_inst.send(CMD_READY, 0);
        `CHK("shut_cmd", 2'b00, {cmd_taken_out, cmd_ignored_out})
        `CHK("shut_hold", ST_SHUTDOWN, state_out)
        ros_host_model_inst.power(1'b0);
        for (int i = 0; i < 4 && state_out !== ST_READY; i++) @(negedge mclk_in);
        `CHK("wake", ST_READY, state_out)
        `CHK("cfg_undef", 1'b0, config_valid_out)
    endtask

    // Outputs are checked before the random pin data moves on.
    always @(negedge mclk_in) begin
        if (!rst_in && state_out === ST_SHUTDOWN) begin
            `CHK("gpio_oe", 4'h0, gpio_oe_out)
            `CHK("miso_oe", 1'b0, spi_miso_oe_out)
        end else if (!rst_in) begin
            `CHK("gpio", gpio_drive_in, gpio_out)
            `CHK("gpio_en", gpio_en_in, gpio_oe_out)
            `CHK("miso", spi_miso_drive_in, spi_miso_out)
            `CHK("miso_drv", 1'b1, spi_miso_oe_out)
            `CHK("no_swap", 1'b0, {prev, state_out} inside {{ST_TX, ST_RX}, {ST_RX, ST_TX}})
        end
        prev = state_out;
        gpio_drive_in = 4'($urandom);
        gpio_en_in = 4'($urandom);
        spi_miso_drive_in = 1'($urandom);
    end

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict;
        end
    end

    initial begin
        rst_in = 1'b1;
        cfg_write_in = 1'b0;
        data_write_in = 1'b0;
        gpio_drive_in = 4'h0;
        gpio_en_in = 4'h0;
        spi_miso_drive_in = 1'b0;
        prev = 3'h0;
        void'($urandom(32'h6954A6EC));
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b0;
        @(negedge mclk_in);
        `CHK("boot", ST_READY, state_out)
        writes;
        do_cmd(CMD_STANDBY, 0, 1'b1);
        `CHK("cfg_kept", 1'b1, config_valid_out)
        `CHK("data_kept", 1'b1, data_valid_out)
        do_cmd(CMD_TX, 0, 1'b1);
        do_cmd(CMD_READY, 0, 1'b1);
        do_cmd(CMD_TX, 0, 1'b0);
        do_cmd(CMD_RX, 0, 1'b1);
        do_cmd(CMD_TX, 0, 1'b1);
        do_cmd(CMD_TX, 1, 1'b1);
        for (int i = 0; i < 200; i++) begin
            if (i % 50 == 49) shut;
            do_cmd(3'($urandom_range(0, 6)), $urandom_range(0, 2), 1'b1);
        end
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire

// ===== verilog/ros_state_ctrl.sv
// Operating-state controller of the sub-GHz transceiver.
`timescale 1ns/1ps
`default_nettype none

module ros_state_ctrl
    import ros_pkg::*;
#(
    parameter int LOCK_CYCLES_P = LOCK_CYCLES
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              shutdown_control_pin_in,
    input  wire logic              cmd_valid_in,
    input  wire logic [CMD_W-1:0]  cmd_code_in,
    input  wire logic              cfg_write_in,
    input  wire logic              data_write_in,
    input  wire logic [GPIO_W-1:0] gpio_drive_in,
    input  wire logic [GPIO_W-1:0] gpio_en_in,
    input  wire logic              spi_miso_drive_in,
    output logic [2:0]             state_out,
    output logic                   cmd_taken_out,
    output logic                   cmd_ignored_out,
    output logic                   crystal_reference_oscillator_on_out,
    output logic                   local_oscillator_signal_on_out,
    output logic                   lock_settled_out,
    output logic                   tx_on_out,
    output logic                   rx_on_out,
    output logic [GPIO_W-1:0]      gpio_out,
    output logic [GPIO_W-1:0]      gpio_oe_out,
    output logic                   spi_miso_out,
    output logic                   spi_miso_oe_out,
    output logic                   config_valid_out,
    output logic                   data_valid_out
);

    ros_state_e            state;
    ros_state_e            next_state;
    ros_goal_e             goal;
    ros_goal_e             next_goal;
    logic [LOCK_CNT_W-1:0] lock_cnt;
    logic [LOCK_CNT_W-1:0] next_lock_cnt;
    logic                  lock_settled;
    logic                  next_lock_settled;

    // Which commands each state accepts.
    function automatic logic cmd_allowed(input ros_state_e st, input logic [CMD_W-1:0] cmd);
        logic ok;
        ok = 1'b0;
        case (st)
            ST_READY:   ok = (cmd == CMD_LOCK) || (cmd == CMD_TX) || (cmd == CMD_RX) ||
                             (cmd == CMD_SLEEP) || (cmd == CMD_STANDBY);
            ST_LOCK:    ok = (cmd == CMD_READY) || (cmd == CMD_LOCK) ||
                             (cmd == CMD_TX) || (cmd == CMD_RX);
            ST_TX:      ok = (cmd == CMD_READY) || (cmd == CMD_LOCK) || (cmd == CMD_RX);
            ST_RX:      ok = (cmd == CMD_READY) || (cmd == CMD_LOCK) || (cmd == CMD_TX);
            ST_SLEEP:   ok = (cmd == CMD_READY);
            ST_STANDBY: ok = (cmd == CMD_READY);
            default:    ok = 1'b0;
        endcase
        return ok;
    endfunction

    // The crystal reference runs in every awake state that may need the synthesiser.
    function automatic logic ref_needed(input ros_state_e st);
        return (st == ST_READY) || (st == ST_LOCK) || (st == ST_TX) || (st == ST_RX);
    endfunction

    function automatic logic synth_needed(input ros_state_e st);
        return (st == ST_LOCK) || (st == ST_TX) || (st == ST_RX);
    endfunction

    wire logic pin_off    = shutdown_control_pin_in;
    wire logic cmd_legal  = cmd_allowed(state, cmd_code_in);
    wire logic cmd_accept = cmd_valid_in && !pin_off && cmd_legal;
    wire logic cmd_refuse = cmd_valid_in && !pin_off && !cmd_legal && (state != ST_SHUTDOWN);
    wire logic lock_last  = (lock_cnt == LOCK_CNT_W'(LOCK_CYCLES_P - 1));
    wire logic powered    = (next_state != ST_SHUTDOWN);

    always_comb begin
        next_state = state;
        if (pin_off) begin
            next_state = ST_SHUTDOWN;
        end else if (state == ST_SHUTDOWN) begin
            next_state = ST_READY;
        end else if (cmd_accept) begin
            case (cmd_code_in)
                CMD_READY:   next_state = ST_READY;
                CMD_LOCK:    next_state = ST_LOCK;
                // A swap between TX and RX is routed into LOCK first.
                CMD_TX:      next_state = ST_LOCK;
                CMD_RX:      next_state = ST_LOCK;
                CMD_SLEEP:   next_state = ST_SLEEP;
                CMD_STANDBY: next_state = ST_STANDBY;
                default:     next_state = state;
            endcase
        end else if ((state == ST_LOCK) && lock_settled && (goal == GOAL_TX)) begin
            next_state = ST_TX;
        end else if ((state == ST_LOCK) && lock_settled && (goal == GOAL_RX)) begin
            next_state = ST_RX;
        end
    end

    // A plain lock command drops any pending activity, so the device parks in LOCK.
    always_comb begin
        next_goal = goal;
        if (cmd_accept && (cmd_code_in == CMD_TX)) begin
            next_goal = GOAL_TX;
        end else if (cmd_accept && (cmd_code_in == CMD_RX)) begin
            next_goal = GOAL_RX;
        end else if (cmd_accept && (cmd_code_in == CMD_LOCK)) begin
            next_goal = GOAL_NONE;
        end
        if (next_state != ST_LOCK) begin
            next_goal = GOAL_NONE;
        end
    end

    // Every entry into LOCK restarts the settling count, so a swap always relocks.
    always_comb begin
        next_lock_cnt  = '0;
        next_lock_settled = 1'b0;
        if ((next_state == ST_TX) || (next_state == ST_RX)) begin
            next_lock_settled = 1'b1;
        end else if ((state == ST_LOCK) && (next_state == ST_LOCK)) begin
            // Staying in LOCK keeps the count, so a new goal waits only for the rest.
            next_lock_settled = lock_settled || lock_last;
            next_lock_cnt  = (lock_settled || lock_last) ? lock_cnt : lock_cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state        <= ST_SHUTDOWN;
            goal         <= GOAL_NONE;
            lock_cnt     <= '0;
            lock_settled <= 1'b0;
        end else begin
            state        <= next_state;
            goal         <= next_goal;
            lock_cnt     <= next_lock_cnt;
            lock_settled <= next_lock_settled;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_taken_out   <= 1'b0;
            cmd_ignored_out <= 1'b0;
        end else begin
            cmd_taken_out   <= cmd_accept;
            cmd_ignored_out <= cmd_refuse;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            crystal_reference_oscillator_on_out <= 1'b0;
            local_oscillator_signal_on_out      <= 1'b0;
            lock_settled_out                    <= 1'b0;
            tx_on_out                           <= 1'b0;
            rx_on_out                           <= 1'b0;
        end else begin
            crystal_reference_oscillator_on_out <= ref_needed(next_state);
            local_oscillator_signal_on_out      <= synth_needed(next_state);
            lock_settled_out                    <= next_lock_settled;
            tx_on_out                           <= (next_state == ST_TX);
            rx_on_out                           <= (next_state == ST_RX);
        end
    end

    // Pin drivers are released from the same edge that enters shutdown.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            gpio_out        <= '0;
            gpio_oe_out     <= '0;
            spi_miso_out    <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end else begin
            gpio_out        <= powered ? gpio_drive_in : '0;
            gpio_oe_out     <= powered ? gpio_en_in : '0;
            spi_miso_out    <= powered && spi_miso_drive_in;
            spi_miso_oe_out <= powered;
        end
    end

    // With no supply nothing is retained; sleep and standby keep everything.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            config_valid_out <= 1'b0;
            data_valid_out   <= 1'b0;
        end else begin
            config_valid_out <= powered && (config_valid_out || cfg_write_in);
            data_valid_out   <= powered && (data_valid_out || data_write_in);
        end
    end

    // The state code leaves straight from the state register.
    assign state_out = state;

    chk_shutdown_entry: assert property (@(posedge mclk_in) disable iff (rst_in)
        pin_off |=> (state == ST_SHUTDOWN) && !crystal_reference_oscillator_on_out)
        else $error("Shutdown pin did not force shutdown.");

    chk_config_lost: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state == ST_SHUTDOWN) |-> !config_valid_out && !data_valid_out)
        else $error("Stored contents survived shutdown.");

    chk_shutdown_hiz: assert property (@(posedge mclk_in) disable iff (rst_in)
        pin_off |=> (gpio_oe_out == '0) && !spi_miso_oe_out)
        else $error("Outputs driven during shutdown.");

    chk_release_ready: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_SHUTDOWN) && !pin_off) |=>
            (state == ST_READY) && crystal_reference_oscillator_on_out)
        else $error("Release from shutdown did not reach ready.");

    chk_lock_settle: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(lock_settled) && (state == ST_LOCK) |->
            ($past(lock_cnt) == LOCK_CNT_W'(LOCK_CYCLES_P - 1)))
        else $error("Lock reported before settling time.");

    chk_no_direct_swap: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_TX) |=> (state != ST_RX)) and ((state == ST_RX) |=> (state != ST_TX)))
        else $error("Direct swap between transmit and receive.");

    chk_tx_via_lock: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_READY) && cmd_valid_in && (cmd_code_in == CMD_TX) && !pin_off) |=>
            (state == ST_LOCK) && (goal == GOAL_TX) && local_oscillator_signal_on_out)
        else $error("Transmit command did not enter lock.");

    chk_lock_finish: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_LOCK) && lock_settled && (goal == GOAL_RX) && !cmd_valid_in && !pin_off)
            |=> (state == ST_RX) && rx_on_out)
        else $error("Locked step did not enter receive.");

    chk_sleep_from_ready: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_SLEEP) && ($past(state) != ST_SLEEP)) |-> ($past(state) == ST_READY))
        else $error("Sleep entered from a state other than ready.");

    chk_standby_keeps: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_STANDBY) && !pin_off && config_valid_out) |=> config_valid_out)
        else $error("Standby lost configuration.");

    chk_cmd_only: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state != next_state) && !pin_off && (state != ST_SHUTDOWN) && (state != ST_LOCK))
            |-> cmd_accept)
        else $error("State changed without a command.");

    chk_ignored_stays: assert property (@(posedge mclk_in) disable iff (rst_in)
        cmd_refuse |=> $stable(state) || ($past(state) == ST_LOCK))
        else $error("Refused command changed the state.");

    chk_ignored_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        cmd_refuse |=> cmd_ignored_out && !cmd_taken_out)
        else $error("Refused command not reported.");

    chk_lock_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state != ST_LOCK) && (next_state == ST_LOCK)) |=> (lock_cnt == '0) && !lock_settled)
        else $error("Lock entry did not restart settling.");

    chk_tx_entry: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_TX) && ($past(state) != ST_TX)) |-> ($past(state) == ST_LOCK))
        else $error("Transmit entered without passing lock.");

    chk_rx_entry: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_RX) && ($past(state) != ST_RX)) |-> ($past(state) == ST_LOCK))
        else $error("Receive entered without passing lock.");

    chk_ready_return: assert property (@(posedge mclk_in) disable iff (rst_in)
        (((state == ST_TX) || (state == ST_RX)) && cmd_accept && (cmd_code_in == CMD_READY))
            |=> (state == ST_READY) && !tx_on_out && !rx_on_out)
        else $error("Activity did not return to ready.");

    chk_standby_entry: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_STANDBY) && ($past(state) != ST_STANDBY)) |-> ($past(state) == ST_READY))
        else $error("Standby entered from a state other than ready.");

    chk_standby_data: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_STANDBY) && !pin_off && data_valid_out) |=> data_valid_out)
        else $error("Standby lost stored data.");

    chk_taken_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        cmd_accept |=> cmd_taken_out && !cmd_ignored_out)
        else $error("Accepted command not reported.");

    chk_wake_drivers: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((state == ST_SHUTDOWN) && !pin_off) |=> spi_miso_oe_out)
        else $error("Serial output not driven after wake.");

endmodule // ros_state_ctrl

`default_nettype wire
